/* include/mab_pkg.sv */
// package of constants, types and encodings for the bit-ops datapath
// Behaviour
// - add immediate to accumulator, flags updated
// - and immediate into accumulator, zero only
// - and accumulator with file, zero only
// - add accumulator and file, all flags
// - destination bit picks accumulator or file
// - bit clear in file, flags untouched
// - bit set in file, flags untouched
// - bit test skips next when one
// - clear file writes zero, sets zero
package mab_pkg;
   localparam int MAB_ADDR_W = 7;
   localparam int MAB_DEPTH = 128;
   localparam int MAB_DATA_W = 8;
   localparam logic [7:0] MAB_ZERO_BYTE = 8'h00;
   localparam logic [7:0] MAB_ACC_RESET = 8'h00;

   // apb register byte addresses
   localparam logic [11:0] MAB_OFS_INSTR = 12'h000;
   localparam logic [11:0] MAB_OFS_ACC = 12'h004;
   localparam logic [11:0] MAB_OFS_STATUS = 12'h008;
   localparam logic [11:0] MAB_OFS_FADDR = 12'h00C;
   localparam logic [11:0] MAB_OFS_FDATA = 12'h010;

   // instruction word field positions
   localparam int MAB_OP_LSB = 16;
   localparam int MAB_DEST_BIT = 15;
   localparam int MAB_BIT_LSB = 8;
   localparam int MAB_KF_LSB = 0;

   // status field positions
   localparam int MAB_ST_C = 0;
   localparam int MAB_ST_NB = 1;
   localparam int MAB_ST_Z = 2;
   localparam int MAB_ST_SKIP = 3;

   typedef enum logic [3:0] {
      MAB_NO_OPERATION = 4'h0,
      MAB_ADD_IMMEDIATE_TO_ACC = 4'h1,
      MAB_AND_IMMEDIATE_WITH_ACC = 4'h2,
      MAB_AND_ACC_WITH_FILE = 4'h3,
      MAB_ADD_ACC_AND_FILE = 4'h4,
      MAB_CLEAR_FILE_BIT = 4'h5,
      MAB_SET_FILE_BIT = 4'h6,
      MAB_TEST_BIT_SKIP_WHEN_ONE = 4'h7,
      MAB_CLEAR_FILE_REGISTER = 4'h8
   } mab_op_t;

   typedef enum logic [1:0] {
      MAB_IDLE = 2'b00,
      MAB_READ = 2'b01,
      MAB_EXEC = 2'b10
   } mab_state_t;

   typedef struct packed {
      logic carry;
      logic nibble_overflow_bit;
      logic zero;
   } mab_flags_t;

   typedef struct packed {
      mab_op_t op;
      logic dest;
      logic [2:0] bit_sel;
      logic [7:0] operand;
   } mab_instr_t;
endpackage : mab_pkg

/* src/mab_file_ram.sv */
// file register memory with registered read data
`timescale 1ns/1ps
module mab_file_ram #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // clock
   input wire logic pclk,
   // write port
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [DATA_W-1:0] wdata,
   // read port
   input wire logic [ADDR_W-1:0] raddr,
   output logic [DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : mab_file_ram

/* src/mab_alu.sv */
// bit-ops datapath with apb register access
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module mab_alu (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // status
   output mab_pkg::mab_flags_t flags,
   output logic skip_next
);
   import mab_pkg::*;

   mab_state_t state, next_state;
   logic [7:0] acc, next_acc;
   mab_flags_t next_flags;
   logic next_skip_next;
   logic [6:0] file_addr, next_file_addr;
   mab_instr_t instr, next_instr;
   logic [31:0] next_prdata;
   logic next_pslverr;

   logic ram_we;
   logic [6:0] ram_waddr, ram_raddr;
   logic [7:0] ram_wdata, ram_rdata;

   logic wr_acc, rd_acc, acc_phase;
   logic busy, first_acc;
   logic resp_rdy, next_resp_rdy;

   function automatic logic [9:0] add_flags(input logic [7:0] a,
                                            input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, b};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      add_flags = {full[8], low[4], full[7:0]};
   endfunction : add_flags

   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = 8'h01 << sel;
   endfunction : bit_mask

   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = a == MAB_OFS_INSTR || a == MAB_OFS_ACC
                || a == MAB_OFS_STATUS || a == MAB_OFS_FADDR
                || a == MAB_OFS_FDATA;
   endfunction : reg_hit

   assign acc_phase = psel && penable;
   // writes and file accesses wait while an instruction executes
   assign busy = state != MAB_IDLE
                 && (pwrite || (paddr != MAB_OFS_ACC
                                && paddr != MAB_OFS_STATUS));
   // one wait state: response is registered before pready rises
   assign first_acc = acc_phase && !busy && !resp_rdy;
   assign pready = resp_rdy;
   assign wr_acc = acc_phase && pwrite && resp_rdy;
   assign rd_acc = first_acc && !pwrite;

   mab_file_ram #(
      .ADDR_W(MAB_ADDR_W),
      .DATA_W(MAB_DATA_W)
   ) u_ram (
      .pclk(pclk),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr(ram_raddr),
      .rdata(ram_rdata)
   );

   always_comb begin
      logic [9:0] sum;
      logic [7:0] res;
      logic wb_file;
      sum = 10'h000;
      res = 8'h00;
      wb_file = 1'b0;
      next_state = state;
      next_acc = acc;
      next_flags = flags;
      next_skip_next = skip_next;
      next_file_addr = file_addr;
      next_instr = instr;
      ram_we = 1'b0;
      ram_waddr = file_addr;
      ram_wdata = 8'h00;
      ram_raddr = instr.operand[6:0];
      case (state)
         MAB_IDLE: begin
            if (wr_acc && pready) begin
               case (paddr)
                  MAB_OFS_INSTR: begin
                     next_instr.op = mab_op_t'(pwdata[MAB_OP_LSB +: 4]);
                     next_instr.dest = pwdata[MAB_DEST_BIT];
                     next_instr.bit_sel = pwdata[MAB_BIT_LSB +: 3];
                     next_instr.operand = pwdata[MAB_KF_LSB +: 8];
                     ram_raddr = pwdata[MAB_KF_LSB +: 7];
                     next_state = MAB_READ;
                  end
                  MAB_OFS_ACC: begin
                     if (pstrb[0]) begin
                        next_acc = pwdata[7:0];
                     end
                  end
                  MAB_OFS_STATUS: begin
                     if (pstrb[0]) begin
                        next_flags.carry = pwdata[MAB_ST_C];
                        next_flags.nibble_overflow_bit = pwdata[MAB_ST_NB];
                        next_flags.zero = pwdata[MAB_ST_Z];
                        next_skip_next = pwdata[MAB_ST_SKIP];
                     end
                  end
                  MAB_OFS_FADDR: begin
                     next_file_addr = pwdata[6:0];
                  end
                  MAB_OFS_FDATA: begin
                     if (pstrb[0]) begin
                        ram_we = 1'b1;
                        ram_waddr = file_addr;
                        ram_wdata = pwdata[7:0];
                     end
                  end
                  default: begin
                     ram_we = 1'b0;
                  end
               endcase
            end
            if (!acc_phase) begin
               ram_raddr = file_addr;
            end
         end
         MAB_READ: begin
            next_state = MAB_EXEC;
         end
         MAB_EXEC: begin
            next_state = MAB_IDLE;
            // instruction after a taken skip runs as no_operation and clears skip_next
            if (skip_next) begin
               next_skip_next = 1'b0;
            end else begin
               case (instr.op)
                  MAB_ADD_IMMEDIATE_TO_ACC: begin
                     sum = add_flags(acc, instr.operand);
                     next_acc = sum[7:0];
                     next_flags.carry = sum[9];
                     next_flags.nibble_overflow_bit = sum[8];
                     next_flags.zero = sum[7:0] == MAB_ZERO_BYTE;
                  end
                  MAB_AND_IMMEDIATE_WITH_ACC: begin
                     res = acc & instr.operand;
                     next_acc = res;
                     next_flags.zero = res == MAB_ZERO_BYTE;
                  end
                  MAB_AND_ACC_WITH_FILE: begin
                     res = acc & ram_rdata;
                     next_flags.zero = res == MAB_ZERO_BYTE;
                     wb_file = instr.dest;
                     if (!instr.dest) begin
                        next_acc = res;
                     end
                  end
                  MAB_ADD_ACC_AND_FILE: begin
                     sum = add_flags(acc, ram_rdata);
                     res = sum[7:0];
                     next_flags.carry = sum[9];
                     next_flags.nibble_overflow_bit = sum[8];
                     next_flags.zero = res == MAB_ZERO_BYTE;
                     wb_file = instr.dest;
                     if (!instr.dest) begin
                        next_acc = res;
                     end
                  end
                  MAB_CLEAR_FILE_BIT: begin
                     res = ram_rdata & ~bit_mask(instr.bit_sel);
                     wb_file = 1'b1;
                  end
                  MAB_SET_FILE_BIT: begin
                     res = ram_rdata | bit_mask(instr.bit_sel);
                     wb_file = 1'b1;
                  end
                  MAB_TEST_BIT_SKIP_WHEN_ONE: begin
                     next_skip_next = |(ram_rdata & bit_mask(instr.bit_sel));
                  end
                  MAB_CLEAR_FILE_REGISTER: begin
                     res = MAB_ZERO_BYTE;
                     next_flags.zero = 1'b1;
                     wb_file = 1'b1;
                  end
                  default: begin
                     res = 8'h00;
                  end
               endcase
            end
            ram_we = wb_file;
            ram_waddr = instr.operand[6:0];
            ram_wdata = res;
            ram_raddr = file_addr;
         end
         default: begin
            next_state = MAB_IDLE;
         end
      endcase
   end

   // bus response: data and error registered in first access cycle
   always_comb begin
      next_resp_rdy = first_acc;
      next_pslverr = first_acc && !reg_hit(paddr);
      next_prdata = prdata;
      if (rd_acc) begin
         case (paddr)
            MAB_OFS_INSTR:
               next_prdata = {12'h000, instr.op, instr.dest, 4'h0,
                              instr.bit_sel, instr.operand};
            MAB_OFS_ACC:
               next_prdata = {24'h00_0000, next_acc};
            MAB_OFS_STATUS:
               next_prdata = {28'h000_0000, next_skip_next,
                              next_flags.zero,
                              next_flags.nibble_overflow_bit,
                              next_flags.carry};
            MAB_OFS_FADDR:
               next_prdata = {25'h000_0000, file_addr};
            MAB_OFS_FDATA:
               next_prdata = {24'h00_0000, ram_rdata};
            default: begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= MAB_IDLE;
         acc <= MAB_ACC_RESET;
         flags <= '0;
         skip_next <= 1'b0;
         file_addr <= '0;
         instr <= '0;
      end else begin
         state <= next_state;
         acc <= next_acc;
         flags <= next_flags;
         skip_next <= next_skip_next;
         file_addr <= next_file_addr;
         instr <= next_instr;
      end
   end

   // bus response registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         resp_rdy <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         resp_rdy <= next_resp_rdy;
      end
   end
endmodule : mab_alu

/* dv/mab_alu_monitor.sv */
// flag side-effect checker for the bit-ops datapath
`timescale 1ns/1ps
module mab_alu_monitor
   import mab_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // status
   input wire mab_flags_t flags,
   input wire logic skip_next
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic wr;
   logic go;
   logic [3:0] op;
   assign wr = psel && penable && pready && pwrite && paddr == 12'h000;
   assign go = wr && !skip_next;
   assign op = pwdata[19:16];
   clr_zero_a: assert property (
      go && op == MAB_CLEAR_FILE_REGISTER |-> ##[1:4] flags.zero)
      else $error("clear left zero low");
   bclr_flags_a: assert property (
      go && op == MAB_CLEAR_FILE_BIT |=> $stable(flags) [*4])
      else $error("bit clear moved flags");
   bset_flags_a: assert property (
      go && op == MAB_SET_FILE_BIT |=> $stable(flags) [*4])
      else $error("bit set moved flags");
   test_flags_a: assert property (
      go && op == MAB_TEST_BIT_SKIP_WHEN_ONE |=> $stable(flags) [*4])
      else $error("bit test moved flags");
   skip_quiet_a: assert property (
      wr && skip_next |=> $stable(flags) [*4])
      else $error("skipped op moved flags");
   andk_carry_a: assert property (
      go && op == MAB_AND_IMMEDIATE_WITH_ACC |=>
      ($stable(flags.carry) && $stable(flags.nibble_overflow_bit)) [*4])
      else $error("and moved carries");
   andk_zero_a: assert property (
      go && op == MAB_AND_IMMEDIATE_WITH_ACC && pwdata[7:0] == 8'h00
      |-> ##[1:4] flags.zero) else $error("and zero missed");
   addz_clear_a: assert property (
      go && op == MAB_ADD_IMMEDIATE_TO_ACC && pwdata[7:0] == 8'h00
      |-> ##[1:4] !flags.carry && !flags.nibble_overflow_bit)
      else $error("add zero kept carry");
   cover property (go && op == MAB_TEST_BIT_SKIP_WHEN_ONE);
   cover property ($rose(skip_next));
   cover property ($rose(flags.carry));
endmodule : mab_alu_monitor

bind mab_alu mab_alu_monitor mon_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .flags(flags), .skip_next(skip_next));

/* dv/mab_alu_tb_top.sv */
// self-checking bench for the bit-ops datapath
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mab_alu_tb_top;
   import mab_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   mab_flags_t flags;
   logic skip_next;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   mab_alu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flags(flags), .skip_next(skip_next));
   always #2 pclk = ~pclk;
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic ex(input mab_op_t o, input logic t, input logic [2:0] b,
      input logic [7:0] k);
      apb(1'b1, 12'h000, {12'h000, o, t, 4'h0, b, k});
      repeat (4) @(posedge pclk);
   endtask : ex
   task automatic rc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, e})
   endtask : rc
   // e is skip, zero, nibble carry, carry
   task automatic st(input logic [3:0] e);
      rc(12'h008, {4'h0, e});
      `CHK({flags, skip_next}, {e[0], e[1], e[2], e[3]})
   endtask : st
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      st(4'h0);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'hff);
      st(4'h0);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'h01);
      rc(12'h004, 8'h00);
      st(4'h7);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'h08);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'h08);
      st(4'h2);
      ex(MAB_AND_IMMEDIATE_WITH_ACC, 1'b0, 3'd0, 8'h00);
      st(4'h6);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'hf0);
      apb(1'b1, 12'h00c, 32'h0000_007f);
      apb(1'b1, 12'h010, 32'h0000_003c);
      ex(MAB_AND_ACC_WITH_FILE, 1'b1, 3'd0, 8'h7f);
      rc(12'h010, 8'h30);
      rc(12'h004, 8'hf0);
      ex(MAB_ADD_ACC_AND_FILE, 1'b1, 3'd0, 8'h7f);
      rc(12'h010, 8'h20);
      st(4'h1);
      ex(MAB_AND_ACC_WITH_FILE, 1'b0, 3'd0, 8'h7f);
      rc(12'h004, 8'h20);
      ex(MAB_CLEAR_FILE_BIT, 1'b0, 3'd5, 8'h7f);
      rc(12'h010, 8'h00);
      st(4'h1);
      ex(MAB_SET_FILE_BIT, 1'b0, 3'd7, 8'h7f);
      rc(12'h010, 8'h80);
      ex(MAB_TEST_BIT_SKIP_WHEN_ONE, 1'b0, 3'd7, 8'h7f);
      st(4'h9);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'h01);
      rc(12'h004, 8'h20);
      st(4'h1);
      ex(MAB_TEST_BIT_SKIP_WHEN_ONE, 1'b0, 3'd0, 8'h7f);
      ex(MAB_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'd0, 8'h00);
      st(4'h0);
      ex(MAB_CLEAR_FILE_REGISTER, 1'b1, 3'd0, 8'h7f);
      rc(12'h010, 8'h00);
      st(4'h4);
      ex(MAB_SET_FILE_BIT, 1'b0, 3'd0, 8'h7f);
      ex(MAB_TEST_BIT_SKIP_WHEN_ONE, 1'b0, 3'd0, 8'h7f);
      ex(MAB_CLEAR_FILE_REGISTER, 1'b1, 3'd0, 8'h7f);
      rc(12'h010, 8'h01);
      st(4'h4);
      ex(MAB_NO_OPERATION, 1'b1, 3'd0, 8'h7f);
      rc(12'h004, 8'h20);
      rc(12'h010, 8'h01);
      st(4'h4);
      ex(MAB_ADD_ACC_AND_FILE, 1'b0, 3'd0, 8'h7f);
      rc(12'h004, 8'h21);
      rc(12'h010, 8'h01);
      st(4'h0);
      rc(12'h00c, 8'h7f);
      apb(1'b1, 12'h008, 32'h0000_0003);
      st(4'h3);
      apb(1'b1, 12'h044, 32'h0000_00ff);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h040, 32'h0000_0000);
      `CHK({er, rd}, {1'b1, 32'h0000_0000})
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(12'h004, 8'h00);
      st(4'h0);
      wrap_up();
   end
endmodule : mab_alu_tb_top
